//--- core/host_pins_pkg.sv
// Purpose: shared constants of the host port pin configuration block
// Assumes: 32-bit register port, four shared pins
// Notes: pin polarity bit at 0 means active low
package host_pins_pkg;
    // ==================================================
    // widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NPIN = 4;

    // ==================================================
    // pin positions
    localparam int unsigned PIN_STROBE = 0;
    localparam int unsigned PIN_RDSTB = 1;
    localparam int unsigned PIN_REQ = 2;
    localparam int unsigned PIN_ACK = 3;

    // ==================================================
    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POL = 8'h04;
    localparam logic [7:0] OFS_OD = 8'h08;
    localparam logic [7:0] OFS_DIR = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // ==================================================
    // control fields
    localparam int unsigned CTRL_W = 3;
    localparam int unsigned CTRL_HOST = 0;
    localparam int unsigned CTRL_DSTB = 1;
    localparam int unsigned CTRL_DREQ = 2;

    // ==================================================
    // polarity fields
    localparam int unsigned POL_W = 7;
    localparam int unsigned POL_DS = 0;
    localparam int unsigned POL_WR = 1;
    localparam int unsigned POL_RD = 2;
    localparam int unsigned POL_REQ = 3;
    localparam int unsigned POL_TX = 4;
    localparam int unsigned POL_RX = 5;
    localparam int unsigned POL_ACK = 6;

    // ==================================================
    // open-drain fields
    localparam int unsigned OD_W = 3;
    localparam int unsigned OD_REQ = 0;
    localparam int unsigned OD_TX = 1;
    localparam int unsigned OD_RX = 2;

    // ==================================================
    // status fields
    localparam int unsigned STAT_OE = 0;
    localparam int unsigned STAT_KEEP = 4;

    // ==================================================
    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [6:0] POL_RST = 7'h00;
    localparam logic [2:0] OD_RST = 3'h0;
    localparam logic [3:0] DIR_RST = 4'h0;
    localparam logic [3:0] DATA_RST = 4'h0;
endpackage

//--- core/host_pin_cell.sv
// Purpose: one shared pin: polarity, open drain, stop hold and keeper
// Assumes: pad input synchronous to the clock
// Notes: output level and enable come from flip-flops
module host_pin_cell (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_stop,
    // pad side
    input wire logic i_pad_in,
    output logic o_pad_out,
    output logic o_pad_oe,
    output logic o_keep,
    // core side
    input wire logic i_drive_en,
    input wire logic i_drive_val,
    input wire logic i_pol,
    input wire logic i_od,
    output logic o_value_in
);
    typedef struct packed {
        logic out;
        logic oe;
        logic drv;
        logic keep;
    } cell_state_t;

    cell_state_t state_reg;
    cell_state_t state_next;
    logic level;

    // ==================================================
    // next state
    always_comb begin
        state_next = state_reg;
        level = i_pol ? i_drive_val : ~i_drive_val;
        if (!i_stop) begin
            state_next.out = level;
            state_next.oe = i_drive_en & (~i_od | ~level);
            state_next.drv = i_drive_en;
            state_next.keep = 1'b0;
        end else begin
            state_next.keep = state_reg.drv;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_pad_out = state_reg.out;
    assign o_pad_oe = state_reg.oe;
    assign o_keep = state_reg.keep;
    // inputs read as inactive in stop or when driven
    assign o_value_in = (i_stop | i_drive_en) ? 1'b0 : (i_pad_in ~^ i_pol);
endmodule

//--- core/host_pin_regs.sv
// Purpose: register port for pin mode, polarity, drive and direction
// Assumes: one-cycle strobes, read data one cycle after the read strobe
// Notes: unmapped reads return zero, unmapped writes are dropped
module host_pin_regs (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bus
    input wire logic [host_pins_pkg::ADDR_W-1:0] i_addr,
    input wire logic [host_pins_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [host_pins_pkg::DATA_W-1:0] o_rdata,
    // status
    input wire logic [3:0] i_level,
    input wire logic [3:0] i_oe,
    input wire logic [3:0] i_keep,
    // settings
    output logic [2:0] o_ctrl,
    output logic [6:0] o_pol,
    output logic [2:0] o_od,
    output logic [3:0] o_dir,
    output logic [3:0] o_data
);
    typedef struct packed {
        logic [2:0] ctrl;
        logic [6:0] pol;
        logic [2:0] od;
        logic [3:0] dir;
        logic [3:0] data;
        logic [31:0] rdata;
    } regs_state_t;

    regs_state_t state_reg;
    regs_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.rdata = '0;
        if (i_wr) begin
            unique case (i_addr)
                host_pins_pkg::OFS_CTRL: state_next.ctrl = i_wdata[2:0];
                host_pins_pkg::OFS_POL: state_next.pol = i_wdata[6:0];
                host_pins_pkg::OFS_OD: state_next.od = i_wdata[2:0];
                host_pins_pkg::OFS_DIR: state_next.dir = i_wdata[3:0];
                host_pins_pkg::OFS_DATA: state_next.data = i_wdata[3:0];
                default: state_next.ctrl = state_reg.ctrl;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                host_pins_pkg::OFS_CTRL: state_next.rdata = {29'h0, state_reg.ctrl};
                host_pins_pkg::OFS_POL: state_next.rdata = {25'h0, state_reg.pol};
                host_pins_pkg::OFS_OD: state_next.rdata = {29'h0, state_reg.od};
                host_pins_pkg::OFS_DIR: state_next.rdata = {28'h0, state_reg.dir};
                host_pins_pkg::OFS_DATA: state_next.rdata = {28'h0, i_level};
                host_pins_pkg::OFS_STAT: state_next.rdata = {24'h0, i_keep, i_oe};
                default: state_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= '{host_pins_pkg::CTRL_RST, host_pins_pkg::POL_RST,
                host_pins_pkg::OD_RST, host_pins_pkg::DIR_RST,
                host_pins_pkg::DATA_RST, 32'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_ctrl = state_reg.ctrl;
    assign o_pol = state_reg.pol;
    assign o_od = state_reg.od;
    assign o_dir = state_reg.dir;
    assign o_data = state_reg.data;
    assign o_rdata = state_reg.rdata;
endmodule

//--- core/host_port_strobe_request_pins.sv
// Purpose: role, polarity and drive of the host port strobe and request pins
// Assumes: pins synchronous to I_CLK_SYS, stop level from the chip
// Notes: pin 0 strobe, pin 1 read strobe, pin 2 request, pin 3 acknowledge
// Behaviour
// - single strobe host mode: pin 0 is the data strobe input
// - double strobe host mode: pin 0 is the write strobe input
// - data strobe polarity programmable, active low after reset
// - write strobe polarity programmable, active low after reset
// - single request host mode: pin 2 drives the combined request
// - double request host mode: pin 2 drives the transmit request
// - double request mode: pin 3 drives the receive request
// - single request mode: pin 3 is acknowledge input driven by host
// - each request polarity programmable, active low after reset
// - acknowledge polarity programmable, active low after reset
// - each request output driven or open drain by setting
// - general-purpose mode turns all four pins into port pins
// - port pin direction set per pin by direction bits
// - double strobe mode: pin 1 is read strobe, polarity programmable
module host_port_strobe_request_pins (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_STOP,
    // register port
    input wire logic [host_pins_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [host_pins_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [host_pins_pkg::DATA_W-1:0] O_RDATA,
    // pads
    input wire logic [3:0] I_PIN_IN,
    output logic [3:0] O_PIN_OUT,
    output logic [3:0] O_PIN_OE,
    output logic [3:0] O_PIN_KEEP,
    // requests from the host port core
    input wire logic I_HOST_REQ,
    input wire logic I_TX_REQ,
    input wire logic I_RX_REQ,
    // strobes to the host port core
    output logic O_DATA_STROBE,
    output logic O_WRITE_STROBE,
    output logic O_READ_STROBE,
    output logic O_READ_WRITE,
    output logic O_ACK
);
    typedef struct packed {
        logic host_data_strobe_in;
        logic host_write_strobe_in;
        logic host_read_strobe_in;
        logic host_read_write_in;
        logic host_ack_in;
    } pins_state_t;

    pins_state_t state_reg;
    pins_state_t state_next;

    logic [2:0] ctrl;
    logic [6:0] pol;
    logic [2:0] od;
    logic [3:0] dir;
    logic [3:0] gpio_data;
    logic [3:0] drive_en;
    logic [3:0] drive_val;
    logic [3:0] pin_pol;
    logic [3:0] pin_od;
    logic [3:0] value_in;
    logic host_on;
    logic dstb;
    logic dreq;
    logic host_request_out;
    logic tx_host_request_out;
    logic rx_host_request_out;

    // ==================================================
    // register port
    host_pin_regs u_regs (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .i_addr(I_ADDR),
        .i_wdata(I_WDATA),
        .i_wr(I_WR),
        .i_rd(I_RD),
        .o_rdata(O_RDATA),
        .i_level(I_PIN_IN),
        .i_oe(O_PIN_OE),
        .i_keep(O_PIN_KEEP),
        .o_ctrl(ctrl),
        .o_pol(pol),
        .o_od(od),
        .o_dir(dir),
        .o_data(gpio_data)
    );

    assign host_on = ctrl[host_pins_pkg::CTRL_HOST];
    assign dstb = ctrl[host_pins_pkg::CTRL_DSTB];
    assign dreq = ctrl[host_pins_pkg::CTRL_DREQ];
    assign host_request_out = I_HOST_REQ;
    assign tx_host_request_out = I_TX_REQ;
    assign rx_host_request_out = I_RX_REQ;

    // ==================================================
    // pin role selection
    always_comb begin
        drive_en = dir;
        drive_val = gpio_data;
        pin_pol = 4'hF;
        pin_od = 4'h0;
        if (host_on) begin
            // strobe pin: polarity follows the strobe style
            drive_en[host_pins_pkg::PIN_STROBE] = 1'b0;
            pin_pol[host_pins_pkg::PIN_STROBE] = dstb ? pol[host_pins_pkg::POL_WR]
                : pol[host_pins_pkg::POL_DS];
            // companion pin: read strobe or plain read/write level
            drive_en[host_pins_pkg::PIN_RDSTB] = 1'b0;
            pin_pol[host_pins_pkg::PIN_RDSTB] = dstb ? pol[host_pins_pkg::POL_RD] : 1'b1;
            // request pin always drives in host mode
            drive_en[host_pins_pkg::PIN_REQ] = 1'b1;
            if (dreq) begin
                drive_val[host_pins_pkg::PIN_REQ] = tx_host_request_out;
                pin_pol[host_pins_pkg::PIN_REQ] = pol[host_pins_pkg::POL_TX];
                pin_od[host_pins_pkg::PIN_REQ] = od[host_pins_pkg::OD_TX];
                drive_en[host_pins_pkg::PIN_ACK] = 1'b1;
                drive_val[host_pins_pkg::PIN_ACK] = rx_host_request_out;
                pin_pol[host_pins_pkg::PIN_ACK] = pol[host_pins_pkg::POL_RX];
                pin_od[host_pins_pkg::PIN_ACK] = od[host_pins_pkg::OD_RX];
            end else begin
                drive_val[host_pins_pkg::PIN_REQ] = host_request_out;
                pin_pol[host_pins_pkg::PIN_REQ] = pol[host_pins_pkg::POL_REQ];
                pin_od[host_pins_pkg::PIN_REQ] = od[host_pins_pkg::OD_REQ];
                drive_en[host_pins_pkg::PIN_ACK] = 1'b0;
                drive_val[host_pins_pkg::PIN_ACK] = 1'b0;
                pin_pol[host_pins_pkg::PIN_ACK] = pol[host_pins_pkg::POL_ACK];
            end
        end
    end

    // ==================================================
    // pad cells
    for (genvar i = 0; i < host_pins_pkg::NPIN; i++) begin : g_pin
        host_pin_cell u_cell (
            .i_clk(I_CLK_SYS),
            .i_rst(I_RST),
            .i_stop(I_STOP),
            .i_pad_in(I_PIN_IN[i]),
            .o_pad_out(O_PIN_OUT[i]),
            .o_pad_oe(O_PIN_OE[i]),
            .o_keep(O_PIN_KEEP[i]),
            .i_drive_en(drive_en[i]),
            .i_drive_val(drive_val[i]),
            .i_pol(pin_pol[i]),
            .i_od(pin_od[i]),
            .o_value_in(value_in[i])
        );
    end

    // ==================================================
    // internal strobes, all low in port pin mode
    always_comb begin
        state_next = '0;
        if (host_on) begin
            state_next.host_data_strobe_in = ~dstb & value_in[host_pins_pkg::PIN_STROBE];
            state_next.host_write_strobe_in = dstb & value_in[host_pins_pkg::PIN_STROBE];
            state_next.host_read_strobe_in = dstb & value_in[host_pins_pkg::PIN_RDSTB];
            state_next.host_read_write_in = ~dstb & value_in[host_pins_pkg::PIN_RDSTB];
            state_next.host_ack_in = ~dreq & value_in[host_pins_pkg::PIN_ACK];
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_DATA_STROBE = state_reg.host_data_strobe_in;
    assign O_WRITE_STROBE = state_reg.host_write_strobe_in;
    assign O_READ_STROBE = state_reg.host_read_strobe_in;
    assign O_READ_WRITE = state_reg.host_read_write_in;
    assign O_ACK = state_reg.host_ack_in;

    // ==================================================
    // checks
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);

    sequence s_single_strobe_low;
        host_on && !dstb && !I_STOP && !I_PIN_IN[0];
    endsequence

    sequence s_stop_entry;
        !I_STOP ##1 I_STOP ##1 I_STOP;
    endsequence

    a_ds_strobe_low: assert property (
        (s_single_strobe_low and (pol[0] == 1'b0)) |=> O_DATA_STROBE && !O_WRITE_STROBE)
        else $error("data strobe not taken on low pin");

    a_ds_strobe_high: assert property (
        (host_on && !dstb && !I_STOP && I_PIN_IN[0] && pol[0])
            |=> O_DATA_STROBE)
        else $error("data strobe polarity not applied");

    a_wr_strobe_map: assert property (
        (host_on && dstb && !I_STOP) |=>
            O_WRITE_STROBE == ($past(I_PIN_IN[0]) ~^ $past(pol[1])) && !O_DATA_STROBE)
        else $error("write strobe mapping wrong");

    a_rd_strobe_map: assert property (
        (host_on && dstb && !I_STOP) |=>
            O_READ_STROBE == ($past(I_PIN_IN[1]) ~^ $past(pol[2])) && !O_READ_WRITE)
        else $error("read strobe mapping wrong");

    a_req_level: assert property (
        (host_on && !dreq && !I_STOP && !od[0]) |=> O_PIN_OE[2]
            && O_PIN_OUT[2] == ($past(pol[3]) ? $past(I_HOST_REQ) : !$past(I_HOST_REQ)))
        else $error("combined request level wrong");

    a_tx_req_level: assert property (
        (host_on && dreq && !I_STOP) |=>
            O_PIN_OUT[2] == ($past(pol[4]) ? $past(I_TX_REQ) : !$past(I_TX_REQ)))
        else $error("transmit request level wrong");

    a_rx_req_level: assert property (
        (host_on && dreq && !I_STOP && !od[2]) |=> O_PIN_OE[3]
            && O_PIN_OUT[3] == ($past(pol[5]) ? $past(I_RX_REQ) : !$past(I_RX_REQ)))
        else $error("receive request level wrong");

    a_ack_input: assert property (
        (host_on && !dreq && !I_STOP) |=> !O_PIN_OE[3]
            && O_ACK == ($past(I_PIN_IN[3]) ~^ $past(pol[6])))
        else $error("acknowledge input wrong");

    a_open_drain: assert property (
        (host_on && !dreq && !I_STOP && od[0] && (I_HOST_REQ == pol[3]))
            |=> !O_PIN_OE[2] && O_PIN_OUT[2])
        else $error("open drain request still driving high");

    a_gpio_dir: assert property (
        (!host_on && !I_STOP) |=> O_PIN_OE == $past(dir)
            && O_PIN_OUT == $past(gpio_data))
        else $error("port pin direction not followed");

    a_gpio_quiet: assert property (
        !host_on |=> !O_DATA_STROBE && !O_WRITE_STROBE && !O_READ_STROBE && !O_ACK
            && !O_READ_WRITE)
        else $error("host strobe seen in port pin mode");

    a_stop_keep: assert property (
        s_stop_entry |-> O_PIN_KEEP == $past(drive_en, 2) && $stable(O_PIN_OUT)
            && $stable(O_PIN_OE))
        else $error("stop hold or keeper wrong");

    a_reset_pol: assert property (
        $fell(I_RST) |-> pol == 7'h00 && od == 3'h0 && ctrl == 3'h0)
        else $error("polarity defaults not active low");
endmodule

//--- bench/host_bus_model.sv
// Purpose: external host on the far side of the shared host port pins
// Assumes: request and acknowledge lines pulled up, strobe lines floating
// Notes: bench picks which pins the host drives and the active levels
module host_bus_model (
    // clock
    input wire logic i_clk,
    // device pads
    input wire logic [3:0] i_out,
    input wire logic [3:0] i_oe,
    // host drive from the bench
    input wire logic [3:0] i_en,
    input wire logic [3:0] i_val,
    input wire logic i_ack_auto,
    input wire logic i_req_act,
    input wire logic i_ack_act,
    // resolved pad levels
    output logic [3:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================
    // floating pattern and acknowledge answer
    logic tog = 1'b0;
    logic ack_reg = 1'b0;

    always @(posedge i_clk) begin
        tog <= ~tog;
        ack_reg <= (o_pin[2] === i_req_act) ? i_ack_act : ~i_ack_act;
    end

    // ==================================================
    // wire resolution: device driver, host driver, pull-up or float
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (i_oe[i]) begin
                o_pin[i] = i_out[i];
            end else if (i == 3 && i_ack_auto) begin
                o_pin[i] = ack_reg;
            end else if (i_en[i]) begin
                o_pin[i] = i_val[i];
            end else begin
                o_pin[i] = (i >= 2) ? 1'b1 : tog;
            end
        end
    end
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench of the host port strobe and request pins
// Assumes: host model resolves the pads, read data one cycle after strobe
// Notes: drivers queue expectations, a watcher on the falling edge compares
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================
    // signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stop = 1'b0;
    logic [host_pins_pkg::ADDR_W-1:0] addr = 8'h00;
    logic [host_pins_pkg::DATA_W-1:0] wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [host_pins_pkg::DATA_W-1:0] rdata;
    logic [3:0] pin;
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] keep;
    logic host_req = 1'b0;
    logic tx_req = 1'b0;
    logic rx_req = 1'b0;
    logic ds, ws, rs, rw, ack;
    logic [3:0] h_en = 4'h0;
    logic [3:0] h_val = 4'h0;
    logic ack_auto = 1'b0;
    logic req_act = 1'b0;
    logic ack_act = 1'b0;
    logic rd_seen = 1'b0;
    logic chk_req = 1'b0;
    logic [31:0] rd_q[$];
    logic [33:0] pin_q[$];
    logic [3:0] dir, dat, hv;
    logic [2:0] ctl;
    logic [1:0] lvl, en;
    logic [7:0] ofs [6];
    int n_errors = 0;
    int num_checks = 0;
    localparam logic [7:0] OFS_NONE = 8'h18;

    always #2 clk = ~clk;

    // ==================================================
    // design and host
    host_port_strobe_request_pins host_port_strobe_request_pins_i (
        .I_CLK_SYS(clk), .I_RST(rst), .I_STOP(stop),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(bus_wr), .I_RD(bus_rd), .O_RDATA(rdata),
        .I_PIN_IN(pin), .O_PIN_OUT(out), .O_PIN_OE(oe), .O_PIN_KEEP(keep),
        .I_HOST_REQ(host_req), .I_TX_REQ(tx_req), .I_RX_REQ(rx_req),
        .O_DATA_STROBE(ds), .O_WRITE_STROBE(ws), .O_READ_STROBE(rs),
        .O_READ_WRITE(rw), .O_ACK(ack)
    );

    host_bus_model host_bus_model_i (
        .i_clk(clk), .i_out(out), .i_oe(oe), .i_en(h_en), .i_val(h_val),
        .i_ack_auto(ack_auto), .i_req_act(req_act), .i_ack_act(ack_act), .o_pin(pin)
    );

    // ==================================================
    // helpers
    function automatic logic [16:0] v(input logic [3:0] o, input logic [3:0] e,
                                      input logic [3:0] k, input logic [4:0] s);
        return {o, e, k, s};
    endfunction

    task automatic close_out;
        if (rd_q.size() != 0 || pin_q.size() != 0) n_errors++;
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] got);
        logic [31:0] e;
        num_checks++;
        e = (rd_q.size() != 0) ? rd_q.pop_front() : 32'hDEAD_BEEF;
        if (got !== e) begin
            n_errors++;
            $display("[ERR] %0t read data %h expected %h", $time, got, e);
        end
    endtask

    task automatic cmp_pin(input logic [16:0] got);
        logic [33:0] em;
        num_checks++;
        em = (pin_q.size() != 0) ? pin_q.pop_front() : {17'h1FFFF, 17'h1FFFF};
        if ((got & em[16:0]) !== (em[33:17] & em[16:0])) begin
            n_errors++;
            $display("[ERR] %0t pins %h expected %h mask %h", $time, got, em[33:17], em[16:0]);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        bus_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        bus_rd <= 1'b0;
    endtask

    task automatic chk(input logic [16:0] e, input logic [16:0] m);
        @(posedge clk);
        pin_q.push_back({e, m});
        chk_req <= 1'b1;
        @(posedge clk);
        chk_req <= 1'b0;
    endtask

    // ==================================================
    // watcher
    always @(posedge clk) rd_seen <= bus_rd;

    always @(negedge clk) begin
        if (rd_seen) cmp_rd(rdata);
        if (chk_req) cmp_pin(v(out, oe, keep, {ds, ws, rs, rw, ack}));
    end

    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        $display("[ERR] %0t run timed out", $time);
        close_out();
    end

    // ==================================================
    // main sequence
    initial begin
        void'($urandom(32'h0AF97A3E));
        ofs = '{host_pins_pkg::OFS_CTRL, host_pins_pkg::OFS_POL, host_pins_pkg::OFS_OD,
                host_pins_pkg::OFS_DIR, host_pins_pkg::OFS_STAT, OFS_NONE};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset state: port mode, inputs, active low, driven
        chk(v(4'h0, 4'h0, 4'h0, 5'h00), v(4'h0, 4'hF, 4'hF, 5'h1D));
        for (int i = 0; i < 6; i++) rd(ofs[i], 32'h0);
        wr(OFS_NONE, 32'hFFFF_FFFF);
        rd(OFS_NONE, 32'h0);
        wr(host_pins_pkg::OFS_STAT, 32'hFFFF_FFFF);
        rd(host_pins_pkg::OFS_STAT, 32'h0);
        wr(host_pins_pkg::OFS_POL, 32'hFFFF_FFFF);
        rd(host_pins_pkg::OFS_POL, 32'h7F);
        // strobe roles and polarity
        for (int m = 0; m < 2; m++) begin
            for (int p = 0; p < 2; p++) begin
                for (int lv = 0; lv < 2; lv++) begin
                    hv = 4'($urandom);
                    wr(host_pins_pkg::OFS_CTRL, (m == 1) ? 32'h3 : 32'h1);
                    wr(host_pins_pkg::OFS_POL, (p == 1) ? 32'h7 : 32'h0);
                    h_en <= 4'h3;
                    h_val <= {2'b00, hv[1], lv[0]};
                    settle(3);
                    if (m == 0) begin
                        chk(v(4'h0, 4'h0, 4'h0, {lv[0] == p[0], 2'b00, hv[1], 1'b0}),
                            v(4'h0, 4'h3, 4'h0, 5'h1F));
                    end else begin
                        chk(v(4'h0, 4'h0, 4'h0, {1'b0, lv[0] == p[0], hv[1] == p[0], 2'b00}),
                            v(4'h0, 4'h3, 4'h0, 5'h1D));
                    end
                end
            end
        end
        // combined request with host acknowledge
        wr(host_pins_pkg::OFS_CTRL, 32'h1);
        h_en <= 4'h0;
        ack_auto <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 2; r++) begin
                wr(host_pins_pkg::OFS_POL, (p == 1) ? 32'h48 : 32'h0);
                req_act <= p[0];
                ack_act <= p[0];
                host_req <= r[0];
                settle(4);
                chk(v({1'b0, ~(r[0] ^ p[0]), 2'b00}, 4'h4, 4'h0, {4'h0, r[0]}),
                    v(4'h4, 4'hC, 4'h0, 5'h01));
            end
        end
        host_req <= 1'b0;
        ack_auto <= 1'b0;
        // transmit and receive requests, driven and open drain
        wr(host_pins_pkg::OFS_CTRL, 32'h5);
        for (int od = 0; od < 2; od++) begin
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 4; k++) begin
                    wr(host_pins_pkg::OFS_OD, (od == 1) ? 32'h7 : 32'h0);
                    wr(host_pins_pkg::OFS_POL, (p == 1) ? 32'h30 : 32'h0);
                    tx_req <= k[0];
                    rx_req <= k[1];
                    settle(3);
                    lvl = {~(k[1] ^ p[0]), ~(k[0] ^ p[0])};
                    en = (od == 1) ? ~lvl : 2'b11;
                    chk(v({lvl, 2'b00}, {en, 2'b00}, 4'h0, 5'h00),
                        v(4'hC, 4'hC, 4'h0, 5'h01));
                end
            end
        end
        tx_req <= 1'b0;
        rx_req <= 1'b0;
        // port pins with random direction, data and host levels
        repeat (4) begin
            ctl = 3'($urandom) & 3'h6;
            dir = 4'($urandom);
            dat = 4'($urandom);
            hv = 4'($urandom);
            wr(host_pins_pkg::OFS_CTRL, {29'h0, ctl});
            wr(host_pins_pkg::OFS_DIR, {28'h0, dir});
            wr(host_pins_pkg::OFS_DATA, {28'h0, dat});
            h_en <= ~dir;
            h_val <= hv;
            settle(3);
            chk(v(dat, dir, 4'h0, 5'h00), v(dir, 4'hF, 4'hF, 5'h1D));
            rd(host_pins_pkg::OFS_DATA, {28'h0, (dat & dir) | (hv & ~dir)});
            rd(host_pins_pkg::OFS_STAT, {28'h0, dir});
        end
        // stop holds outputs and turns keepers on at the driven pins
        dir = 4'h5;
        wr(host_pins_pkg::OFS_DIR, 32'h5);
        h_en <= ~dir;
        settle(3);
        stop <= 1'b1;
        h_val <= ~hv;
        settle(3);
        // new port data while stopped must not reach the pads
        wr(host_pins_pkg::OFS_DATA, {28'h0, ~dat});
        settle(2);
        chk(v(dat, dir, dir, 5'h00), v(dir, 4'hF, 4'hF, 5'h1D));
        stop <= 1'b0;
        settle(3);
        chk(v(~dat, dir, 4'h0, 5'h00), v(dir, 4'hF, 4'hF, 5'h1D));
        settle(3);
        close_out();
    end
endmodule
